// file: src/phy_link_pkg.sv
package phy_link_pkg;

	// ------------------------------------------------------------
	// register indices on the management interface
	// ------------------------------------------------------------
	localparam logic [4:0] GIGABIT_CAPABILITY_STATUS_IDX = 5'h0f;
	localparam logic [4:0] LINK_BEHAVIOUR_CONTROL_IDX    = 5'h10;
	localparam logic [4:0] SLOW_SPEED_MODE_CONTROL_IDX   = 5'h11;

	// ------------------------------------------------------------
	// capability status: fixed value and bit positions
	// ------------------------------------------------------------
	localparam int         CAP_X_FULL_BIT  = 15;
	localparam int         CAP_X_HALF_BIT  = 14;
	localparam int         CAP_T_FULL_BIT  = 13;
	localparam int         CAP_T_HALF_BIT  = 12;
	localparam logic [0:0] CAP_X_VALUE     = 1'h0;
	localparam logic [0:0] CAP_T_VALUE     = 1'h1;

	// ------------------------------------------------------------
	// link behaviour control fields
	// ------------------------------------------------------------
	localparam int         ATTEMPT_HI      = 9;
	localparam int         ATTEMPT_LO      = 8;
	localparam int         BREAK_THR_HI    = 5;
	localparam int         BREAK_THR_LO    = 4;
	localparam int         BREAK_EN_BIT    = 3;
	localparam int         POWER_OPT_BIT   = 2;
	localparam int         LOGIC_RST_BIT   = 0;
	localparam logic [15:0] LINK_RW_MASK   = 16'h033d;
	localparam logic [15:0] LINK_RESET     = 16'h0020;

	// ------------------------------------------------------------
	// slow speed mode control fields
	// ------------------------------------------------------------
	localparam int         SHORT_ED_BIT    = 15;
	localparam int         FAST_TEST_BIT   = 14;
	localparam int         ED_PWRDN_BIT    = 13;
	localparam int         PWRDN_VAR_BIT   = 12;
	localparam int         SPEED_OPT_BIT   = 7;
	localparam int         NEXT_PAGE_BIT   = 6;
	localparam int         XOVER_OFF_BIT   = 5;
	localparam int         ENERGY_BIT      = 1;
	localparam logic [15:0] MODE_RW_MASK   = 16'hf0e0;
	localparam logic [15:0] MODE_RESET     = 16'h0040;

	// ------------------------------------------------------------
	// decode tables and management frame constants
	// ------------------------------------------------------------
	localparam logic [11:0] ATTEMPT_TABLE  = {3'h3, 3'h4, 3'h5, 3'h7};
	localparam logic [3:0]  BREAK_EXP_BASE = 4'h8;
	localparam logic [5:0]  PREAMBLE_LEN   = 6'h20;
	localparam logic [4:0]  HEADER_LEN     = 5'h0d;
	localparam logic [4:0]  DATA_LEN       = 5'h10;
	localparam logic [1:0]  OP_READ        = 2'h2;
	localparam logic [1:0]  OP_WRITE       = 2'h1;

	// decoded controls handed to the device core
	typedef struct packed {
		logic [1:0] attempt_code;
		logic [2:0] attempt_limit;
		logic [1:0] break_threshold_code;
		logic [3:0] break_exponent;
		logic       link_break_enable;
		logic       power_opt_off;
		logic       short_energy_detect_select;
		logic       ten_meg_fast_test_enable;
		logic       energy_detect_powerdown_enable;
		logic       powerdown_pulse_variant;
		logic       speed_opt_enable;
		logic       next_page_allow;
		logic       auto_crossover_off;
	} phy_ctrl_t;

	typedef enum logic [2:0] {S_PRE, S_HDR, S_TA, S_DATA} mgmt_state_t;

endpackage

// file: src/phy_link_control_regs.sv
`timescale 1ns/100ps

module phy_link_control_regs (
	input  wire logic                    SYS_CLK,
	input  wire logic                    ARST_N,
	input  wire logic                    MDC,
	input  wire logic                    MDIO_IN,
	output logic                         MDIO_OUT,
	output logic                         MDIO_OE,
	input  wire logic [4:0]              STATION_ADDRESS,
	input  wire logic                    LINE_ENERGY_DET,
	input  wire logic                    SOFT_RESET,
	output phy_link_pkg::phy_ctrl_t      CTRL,
	output logic                         LOGIC_RESET
);

	// ------------------------------------------------------------
	// reset release and input synchronisers
	// ------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic       rst_n;
	logic [1:0] mdc_sync_r;
	logic [1:0] mdio_sync_r;
	logic [1:0] energy_sync_r;
	logic [4:0] addr_meta_r;
	logic [4:0] addr_sync_r;
	logic       mdc_prev_r;
	logic       mdc_rise;

	// reset asserts at once, releases two edges later
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'h1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// pins other than SOFT_RESET pass two flops; only the second stage feeds logic
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			// idle-high image: the first change after reset is a fall, never a false rise
			mdc_sync_r    <= 2'h3;
			mdio_sync_r   <= 2'h3;
			energy_sync_r <= 2'h0;
			addr_meta_r   <= 5'h00;
			addr_sync_r   <= 5'h00;
			mdc_prev_r    <= 1'h1;
		end else begin
			mdc_sync_r    <= {mdc_sync_r[0], MDC};
			mdio_sync_r   <= {mdio_sync_r[0], MDIO_IN};
			energy_sync_r <= {energy_sync_r[0], LINE_ENERGY_DET};
			addr_meta_r   <= STATION_ADDRESS;
			addr_sync_r   <= addr_meta_r;
			mdc_prev_r    <= mdc_sync_r[1];
		end
	end
	assign mdc_rise = mdc_sync_r[1] & ~mdc_prev_r;

	// ------------------------------------------------------------
	// management frame engine
	// ------------------------------------------------------------
	phy_link_pkg::mgmt_state_t state_r, state_nxt;
	logic [5:0]  pre_cnt_r, pre_cnt_nxt;
	logic [4:0]  bit_cnt_r, bit_cnt_nxt;
	logic [12:0] hdr_r, hdr_nxt;
	logic [15:0] sh_r, sh_nxt;
	logic        out_r, out_nxt;
	logic        oe_r, oe_nxt;
	logic        wr_go;
	logic [15:0] link_r, link_nxt;
	logic [15:0] mode_r, mode_nxt;
	logic        energy_r, energy_nxt;
	logic        logic_reset_strobe_r, logic_reset_strobe_nxt;
	logic        logic_reset_strobe_pulse_nxt;
	logic [15:0] rdata;
	logic        sel_ok;
	logic        is_read;
	logic        is_write;
	logic        din;

	assign din      = mdio_sync_r[1];
	assign is_read  = (hdr_r[11:10] == phy_link_pkg::OP_READ);
	assign is_write = (hdr_r[11:10] == phy_link_pkg::OP_WRITE);
	assign sel_ok   = (hdr_r[9:5] == addr_sync_r);

	// read mux; reserved positions stay zero
	always_comb begin
		rdata = 16'h0000;
		if (hdr_r[4:0] == phy_link_pkg::GIGABIT_CAPABILITY_STATUS_IDX) begin
			rdata[phy_link_pkg::CAP_X_FULL_BIT] = phy_link_pkg::CAP_X_VALUE;
			rdata[phy_link_pkg::CAP_X_HALF_BIT] = phy_link_pkg::CAP_X_VALUE;
			rdata[phy_link_pkg::CAP_T_FULL_BIT] = phy_link_pkg::CAP_T_VALUE;
			rdata[phy_link_pkg::CAP_T_HALF_BIT] = phy_link_pkg::CAP_T_VALUE;
		end else if (hdr_r[4:0] == phy_link_pkg::LINK_BEHAVIOUR_CONTROL_IDX) begin
			rdata = link_r & phy_link_pkg::LINK_RW_MASK;
		end else if (hdr_r[4:0] == phy_link_pkg::SLOW_SPEED_MODE_CONTROL_IDX) begin
			rdata = mode_r & phy_link_pkg::MODE_RW_MASK;
			rdata[phy_link_pkg::ENERGY_BIT] = energy_r;
		end
	end

	// frame sequencing, one step per rising management clock
	always_comb begin
		state_nxt   = state_r;
		pre_cnt_nxt = pre_cnt_r;
		bit_cnt_nxt = bit_cnt_r;
		hdr_nxt     = hdr_r;
		sh_nxt      = sh_r;
		out_nxt     = out_r;
		oe_nxt      = oe_r;
		wr_go       = 1'h0;
		if (mdc_rise) begin
			case (state_r)
				phy_link_pkg::S_PRE: begin
					oe_nxt = 1'h0;
					if (din) begin
						if (pre_cnt_r != phy_link_pkg::PREAMBLE_LEN) begin
							pre_cnt_nxt = pre_cnt_r + 6'h01;
						end
					end else begin
						// a zero after a full preamble is the start mark
						if (pre_cnt_r == phy_link_pkg::PREAMBLE_LEN) begin
							state_nxt   = phy_link_pkg::S_HDR;
							bit_cnt_nxt = 5'h00;
						end
						pre_cnt_nxt = 6'h00;
					end
				end
				phy_link_pkg::S_HDR: begin
					hdr_nxt     = {hdr_r[11:0], din};
					bit_cnt_nxt = bit_cnt_r + 5'h01;
					if (bit_cnt_nxt == phy_link_pkg::HEADER_LEN) begin
						bit_cnt_nxt = 5'h00;
						state_nxt   = phy_link_pkg::S_TA;
						// bad start mark or opcode: wait for a new preamble
						if (!hdr_nxt[12] || (hdr_nxt[11:10] != phy_link_pkg::OP_READ
								&& hdr_nxt[11:10] != phy_link_pkg::OP_WRITE)) begin
							state_nxt = phy_link_pkg::S_PRE;
						end
					end
				end
				phy_link_pkg::S_TA: begin
					if (bit_cnt_r == 5'h00) begin
						bit_cnt_nxt = 5'h01;
						// drive the turnaround zero on a matching read
						if (is_read && sel_ok) begin
							oe_nxt  = 1'h1;
							out_nxt = 1'h0;
						end
					end else begin
						bit_cnt_nxt = 5'h00;
						state_nxt   = phy_link_pkg::S_DATA;
						out_nxt     = rdata[15];
						sh_nxt      = {rdata[14:0], 1'h0};
					end
				end
				default: begin
					bit_cnt_nxt = bit_cnt_r + 5'h01;
					if (is_read) begin
						out_nxt = sh_r[15];
						sh_nxt  = {sh_r[14:0], 1'h0};
					end else begin
						sh_nxt = {sh_r[14:0], din};
					end
					if (bit_cnt_nxt == phy_link_pkg::DATA_LEN) begin
						// release the line after the last data bit
						oe_nxt      = 1'h0;
						out_nxt     = 1'h0;
						state_nxt   = phy_link_pkg::S_PRE;
						pre_cnt_nxt = 6'h00;
						wr_go       = is_write && sel_ok;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// register bank
	// ------------------------------------------------------------
	always_comb begin
		link_nxt   = link_r;
		mode_nxt   = mode_r;
		logic_reset_strobe_nxt   = logic_reset_strobe_r;
		logic_reset_strobe_pulse_nxt = 1'h0;
		energy_nxt = energy_sync_r[1];
		if (SOFT_RESET) begin
			energy_nxt = 1'h0;
		end
		if (wr_go && hdr_r[4:0] == phy_link_pkg::LINK_BEHAVIOUR_CONTROL_IDX) begin
			link_nxt = sh_nxt & phy_link_pkg::LINK_RW_MASK;
			logic_reset_strobe_nxt = sh_nxt[phy_link_pkg::LOGIC_RST_BIT];
			logic_reset_strobe_pulse_nxt = sh_nxt[phy_link_pkg::LOGIC_RST_BIT];
		end else if (wr_go && hdr_r[4:0] == phy_link_pkg::SLOW_SPEED_MODE_CONTROL_IDX) begin
			mode_nxt = sh_nxt & phy_link_pkg::MODE_RW_MASK;
		end
	end

	// decoded control image, changes with the register it follows
	phy_link_pkg::phy_ctrl_t ctrl_nxt;
	always_comb begin
		ctrl_nxt.attempt_code  = link_nxt[phy_link_pkg::ATTEMPT_HI:phy_link_pkg::ATTEMPT_LO];
		ctrl_nxt.attempt_limit = phy_link_pkg::ATTEMPT_TABLE[3*ctrl_nxt.attempt_code +: 3];
		ctrl_nxt.break_threshold_code =
			link_nxt[phy_link_pkg::BREAK_THR_HI:phy_link_pkg::BREAK_THR_LO];
		ctrl_nxt.break_exponent = phy_link_pkg::BREAK_EXP_BASE
			+ {2'h0, ctrl_nxt.break_threshold_code};
		ctrl_nxt.link_break_enable = link_nxt[phy_link_pkg::BREAK_EN_BIT];
		ctrl_nxt.power_opt_off = link_nxt[phy_link_pkg::POWER_OPT_BIT];
		ctrl_nxt.short_energy_detect_select = mode_nxt[phy_link_pkg::SHORT_ED_BIT];
		ctrl_nxt.ten_meg_fast_test_enable = mode_nxt[phy_link_pkg::FAST_TEST_BIT];
		ctrl_nxt.energy_detect_powerdown_enable = mode_nxt[phy_link_pkg::ED_PWRDN_BIT];
		ctrl_nxt.powerdown_pulse_variant = mode_nxt[phy_link_pkg::PWRDN_VAR_BIT];
		ctrl_nxt.speed_opt_enable = mode_nxt[phy_link_pkg::SPEED_OPT_BIT];
		ctrl_nxt.next_page_allow = mode_nxt[phy_link_pkg::NEXT_PAGE_BIT];
		ctrl_nxt.auto_crossover_off = mode_nxt[phy_link_pkg::XOVER_OFF_BIT];
	end

	// reset image of the decoded controls, built from the reset values
	localparam logic [15:0] LR = phy_link_pkg::LINK_RESET;
	localparam logic [15:0] MR = phy_link_pkg::MODE_RESET;
	localparam logic [1:0]  RST_ATTEMPT =
		LR[phy_link_pkg::ATTEMPT_HI:phy_link_pkg::ATTEMPT_LO];
	localparam logic [1:0]  RST_THR     =
		LR[phy_link_pkg::BREAK_THR_HI:phy_link_pkg::BREAK_THR_LO];
	localparam phy_link_pkg::phy_ctrl_t CTRL_RESET = '{
		attempt_code:                   RST_ATTEMPT,
		attempt_limit:                  phy_link_pkg::ATTEMPT_TABLE[3*RST_ATTEMPT +: 3],
		break_threshold_code:           RST_THR,
		break_exponent:                 phy_link_pkg::BREAK_EXP_BASE + {2'h0, RST_THR},
		link_break_enable:              LR[phy_link_pkg::BREAK_EN_BIT],
		power_opt_off:                  LR[phy_link_pkg::POWER_OPT_BIT],
		short_energy_detect_select:     MR[phy_link_pkg::SHORT_ED_BIT],
		ten_meg_fast_test_enable:       MR[phy_link_pkg::FAST_TEST_BIT],
		energy_detect_powerdown_enable: MR[phy_link_pkg::ED_PWRDN_BIT],
		powerdown_pulse_variant:        MR[phy_link_pkg::PWRDN_VAR_BIT],
		speed_opt_enable:               MR[phy_link_pkg::SPEED_OPT_BIT],
		next_page_allow:                MR[phy_link_pkg::NEXT_PAGE_BIT],
		auto_crossover_off:             MR[phy_link_pkg::XOVER_OFF_BIT]
	};

	phy_link_pkg::phy_ctrl_t ctrl_r;
	logic                    logic_reset_strobe_pulse_r;

	// frame, register and control state registered here; hardware reset sets the energy flag
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_r      <= phy_link_pkg::S_PRE;
			pre_cnt_r    <= 6'h00;
			bit_cnt_r    <= 5'h00;
			hdr_r        <= 13'h0000;
			sh_r         <= 16'h0000;
			out_r        <= 1'h0;
			oe_r         <= 1'h0;
			link_r       <= phy_link_pkg::LINK_RESET;
			mode_r       <= phy_link_pkg::MODE_RESET;
			logic_reset_strobe_r       <= 1'h0;
			energy_r     <= 1'h1;
			ctrl_r       <= CTRL_RESET;
			logic_reset_strobe_pulse_r <= 1'h0;
		end else begin
			state_r      <= state_nxt;
			pre_cnt_r    <= pre_cnt_nxt;
			bit_cnt_r    <= bit_cnt_nxt;
			hdr_r        <= hdr_nxt;
			sh_r         <= sh_nxt;
			out_r        <= out_nxt;
			oe_r         <= oe_nxt;
			link_r       <= link_nxt;
			mode_r       <= mode_nxt;
			logic_reset_strobe_r       <= logic_reset_strobe_nxt;
			energy_r     <= energy_nxt;
			ctrl_r       <= ctrl_nxt;
			logic_reset_strobe_pulse_r <= logic_reset_strobe_pulse_nxt;
		end
	end

	// pulse only touches the core; registers above are untouched by it
	assign LOGIC_RESET = logic_reset_strobe_pulse_r;
	assign CTRL        = ctrl_r;
	assign MDIO_OUT    = out_r;
	assign MDIO_OE     = oe_r;

endmodule

// file: tb/phy_link_control_regs_properties.sv
`timescale 1ns/100ps
// ------------------------------------------------
// port checks for the register slice
// ------------------------------------------------
module phy_link_checker (
	input wire logic                    SYS_CLK,
	input wire logic                    ARST_N,
	input wire logic                    MDC,
	input wire logic                    MDIO_OUT,
	input wire logic                    MDIO_OE,
	input wire phy_link_pkg::phy_ctrl_t CTRL,
	input wire logic                    LOGIC_RESET
);
	logic [3:0] idle_r;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);

	// cycles since mdc was last high; saturates so a long idle never wraps
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			idle_r <= 4'hf;
		else if (MDC)
			idle_r <= 4'h0;
		else if (idle_r != 4'hf)
			idle_r <= idle_r + 4'h1;
	end

	a_attempt_map: assert property (
		CTRL.attempt_limit == ((CTRL.attempt_code == 2'h0) ? 3'h7 : (CTRL.attempt_code == 2'h1)
		? 3'h5 : (CTRL.attempt_code == 2'h2) ? 3'h4 : 3'h3)) else $error("attempt limit wrong");
	a_break_scale: assert property (
		CTRL.break_exponent == 4'h8 + {2'h0, CTRL.break_threshold_code}) else $error("bad rate");
	a_pulse_single: assert property (
		LOGIC_RESET |=> !LOGIC_RESET) else $error("logic reset pulse too long");
	a_pulse_frame: assert property (
		LOGIC_RESET |-> idle_r < 4'h3) else $error("logic reset away from mdc edge");
	a_ctrl_write: assert property (
		!$stable(CTRL) |-> idle_r < 4'h3) else $error("control changed away from mdc edge");
	a_ta_zero: assert property (
		$rose(MDIO_OE) |-> (!MDIO_OUT) [*8]) else $error("turnaround not driven low");
	a_oe_rise: assert property (
		$rose(MDIO_OE) |-> idle_r < 4'h3) else $error("drive began away from mdc edge");
	a_out_step: assert property (
		(MDIO_OE && $past(MDIO_OE) && $changed(MDIO_OUT)) |-> idle_r < 4'h3)
		else $error("read bit moved away from mdc edge");
	a_oe_fall: assert property (
		$fell(MDIO_OE) |-> idle_r < 4'h3) else $error("drive ended away from mdc edge");

	c_pulse: cover property (LOGIC_RESET);
	c_read: cover property ($rose(MDIO_OE));
	c_xover: cover property (CTRL.auto_crossover_off && CTRL.link_break_enable);
endmodule

bind phy_link_control_regs phy_link_checker chk_u (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
	.MDC(MDC), .MDIO_OUT(MDIO_OUT), .MDIO_OE(MDIO_OE), .CTRL(CTRL), .LOGIC_RESET(LOGIC_RESET));

// file: tb/testbench.sv
`timescale 1ns/100ps
// ------------------------------------------------
// self-checking bench for the register slice
// ------------------------------------------------
module testbench;
	logic                    sys_clk, arst_n, mdc, mst_d, mst_oe, energy, soft_rst;
	logic                    mdio_out, mdio_oe, logic_reset_strobe;
	logic [4:0]              addr;
	logic [15:0]             link_m, mode_m, d;
	logic [17:0]             rd;
	wire                     mdio_line;
	phy_link_pkg::phy_ctrl_t ctrl;
	integer                  errors, comparisons, pulses, seed, i;

	// pin level: device first, then the bench as master, else the pull-up
	assign mdio_line = mdio_oe ? mdio_out : (mst_oe ? mst_d : 1'h1);

	phy_link_control_regs dut_u (.SYS_CLK(sys_clk), .ARST_N(arst_n), .MDC(mdc),
		.MDIO_IN(mdio_line), .MDIO_OUT(mdio_out), .MDIO_OE(mdio_oe), .STATION_ADDRESS(addr),
		.LINE_ENERGY_DET(energy), .SOFT_RESET(soft_rst), .CTRL(ctrl), .LOGIC_RESET(logic_reset_strobe));

	// 40 MHz system clock
	initial begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// count logic reset pulses, one per cycle seen high
	always @(posedge sys_clk) begin
		if (logic_reset_strobe === 1'h1)
			pulses = pulses + 1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// control image decoded straight from the two register words
	function automatic phy_link_pkg::phy_ctrl_t want(input logic [15:0] l, input logic [15:0] m);
		phy_link_pkg::phy_ctrl_t c;
		c = '0;
		c.attempt_code = l[9:8];
		case (l[9:8])
			2'h0: c.attempt_limit = 3'h7;
			2'h1: c.attempt_limit = 3'h5;
			2'h2: c.attempt_limit = 3'h4;
			default: c.attempt_limit = 3'h3;
		endcase
		c.break_threshold_code = l[5:4];
		c.break_exponent = 4'h8 + {2'h0, l[5:4]};
		c.link_break_enable = l[3];
		c.power_opt_off = l[2];
		{c.short_energy_detect_select, c.ten_meg_fast_test_enable} = m[15:14];
		{c.energy_detect_powerdown_enable, c.powerdown_pulse_variant} = m[13:12];
		{c.speed_opt_enable, c.next_page_allow, c.auto_crossover_off} = m[7:5];
		return c;
	endfunction

	// one mdc period; the pin is sampled just before the rising edge
	task automatic mbit(input logic b);
		mst_d = b;
		mdc = 1'h0;
		repeat (5) @(negedge sys_clk);
		rd = {rd[16:0], mdio_line};
		mdc = 1'h1;
		repeat (5) @(negedge sys_clk);
	endtask

	// whole frame; on a read the bench lets go of the pin from turnaround on
	task automatic frame(input logic wr, input logic [4:0] a, input logic [4:0] r,
		input logic [15:0] v);
		logic [31:0] hdr;
		hdr = {2'h1, wr ? 2'h1 : 2'h2, a, r, 2'h2, v};
		mst_oe = 1'h1;
		repeat (32) mbit(1'h1);
		for (int k = 31; k >= 0; k--) begin
			if (k == 17)
				mst_oe = wr;
			mbit(hdr[k]);
		end
		mst_oe = 1'h1;
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [4:0] r, input logic [15:0] v);
		integer p0;
		logic   hit;
		p0 = pulses;
		hit = (a == addr);
		frame(1'h1, a, r, v);
		if (hit && r == 5'h10)
			link_m = v & 16'h033d;
		if (hit && r == 5'h11)
			mode_m = v & 16'hf0e0;
		chk(pulses - p0, {31'h0, hit && r == 5'h10 && v[0]});
		chk({12'h0, ctrl}, {12'h0, want(link_m, mode_m)});
	endtask

	task automatic rd_reg(input logic [4:0] a, input logic [4:0] r, input logic [17:0] exp);
		frame(1'h0, a, r, 16'h0);
		chk({14'h0, rd}, {14'h0, exp});
	endtask

	// turnaround 1 then 0, then the mode word with the energy flag folded in
	function automatic logic [17:0] mode_rd();
		return {2'h2, mode_m | {14'h0, energy & ~soft_rst, 1'h0}};
	endfunction

	task automatic do_reset;
		arst_n = 1'h0;
		repeat (8) @(negedge sys_clk);
		arst_n = 1'h1;
		repeat (8) @(negedge sys_clk);
		link_m = 16'h0020;
		mode_m = 16'h0040;
		chk({12'h0, ctrl}, {12'h0, want(link_m, mode_m)});
		rd_reg(addr, 5'h0f, {2'h2, 16'h3000});
		rd_reg(addr, 5'h10, {2'h2, link_m});
		rd_reg(addr, 5'h11, mode_rd());
	endtask

	// main sequence
	initial begin
		errors = 0;
		comparisons = 0;
		pulses = 0;
		seed = 79;
		{arst_n, mdc, soft_rst} = 3'h0;
		{mst_d, mst_oe, energy} = 3'h7;
		addr = 5'($random(seed));
		@(negedge sys_clk);
		do_reset;
		// every attempt and threshold code, random remainder
		for (i = 0; i < 8; i++) begin
			d = 16'($random(seed));
			if (i < 4) begin
				d[9:8] = 2'(i);
				d[5:4] = 2'(i);
			end
			energy = d[11];
			wr_reg(addr, 5'h10, d);
			wr_reg(addr, 5'h11, 16'($random(seed)));
			rd_reg(addr, 5'h10, {2'h2, link_m});
			rd_reg(addr, 5'h11, mode_rd());
		end
		// all ones everywhere but 0f, the logic reset bit twice in a row
		wr_reg(addr, 5'h10, 16'hffff);
		wr_reg(addr, 5'h10, 16'hffff);
		wr_reg(addr, 5'h11, 16'hffff);
		wr_reg(addr, 5'h0f, 16'h0000);
		wr_reg(addr, 5'h12, 16'hffff);
		rd_reg(addr, 5'h0f, {2'h2, 16'h3000});
		rd_reg(addr, 5'h12, {2'h2, 16'h0000});
		rd_reg(addr, 5'h10, {2'h2, 16'h033d});
		// another station's frames change nothing and get no answer
		wr_reg(addr ^ 5'h01, 5'h10, 16'h0000);
		rd_reg(addr ^ 5'h10, 5'h10, 18'h3ffff);
		// software reset holds the energy flag clear only while high
		energy = 1'h1;
		soft_rst = 1'h1;
		rd_reg(addr, 5'h11, mode_rd());
		soft_rst = 1'h0;
		rd_reg(addr, 5'h11, mode_rd());
		wr_reg(addr, 5'h10, 16'h0020);
		do_reset;
		summarize;
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge sys_clk);
		errors = errors + 1;
		summarize;
	end
endmodule
